// ---- hdl/dctmr_top.sv ----
// dual 8-bit timer with axi4-lite register slave and shared flag register
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - counter steps on each tick further divided by prescaler 1 to 128.
// - current count readable by software at any time.
// - start bit 1 runs counter, 0 halts and holds count.
// - free-running counts 0x00 to 0xff, wraps, sets terminal count flag.
// - terminal count interrupt only when its mask bit is set.
// - down mode loads channel 0 value on start, counts to 0x00, flags.
// - modulo counts 0x00 to channel 0 value, wraps, flags.
// - up/down counts up to channel 0 value then back to 0x00.
// - clear bit zeroes counter and restores upward direction.
// - two channels, each configured by its own control register.
// - capture mode: pin input, selected edge copies count into channel value.
// - input pins synchronised; source holds pulses over one clock period.
// - capture sets channel flag; interrupt only if channel mask set.
// - compare mode: pin output, set/clear/toggle on count equal compare value.
// - output pin transitions are glitch free.
// - channel 0 compare write applies at count 0x00; channel 1 immediately.
// - compare match sets channel flag; interrupt only if channel mask set.
// - one interrupt request per timer for all its events.
// - one shared flag register holds two terminal and four channel flags.
// - setting a mask while its flag is set raises a new request.
// - prescale codes 000 to 111 divide by 1 to 128.
// - mode codes 00 free, 01 down, 10 modulo, 11 up/down.
// - compare action codes 000 to 110 as set, clear, toggle and pwm forms.
// - edge codes 00 none, 01 rising, 10 falling, 11 both.
module dctmr_top
   import dctmr_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // system tick enable
   input wire logic TICK_EN,
   // axi4-lite write channels
   input wire logic [dctmr_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read channels
   input wire logic [dctmr_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // channel pins, index timer*2+channel
   input wire logic [3:0] CH_PIN_IN,
   output logic [3:0] CH_PIN_OUT,
   output logic [3:0] CH_PIN_OE,
   // per-timer interrupt requests
   output logic [1:0] TMR_IRQ
);
   logic [7:0] ctl_reg [2];
   logic [7:0] cctl_reg [2][2];
   logic [5:0] flag_reg, flag_next;
   logic [2:0] tick_sel_reg;
   logic [3:0] sync1_reg, sync2_reg;
   logic [5:0] irq_en_d_reg;
   logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [7:0] wbyte_reg;
   logic bresp_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [7:0] count_w [2];
   logic [7:0] ccval_w [2][2];
   logic [1:0] tc_ev;
   logic [1:0] ch_ev [2];
   logic [1:0] pout [2];
   logic [1:0] poe [2];
   logic [5:0] irq_en;
   logic [5:0] hw_set;
   logic [5:0] rise_en;
   logic [6:0] tick_div_reg;

   // two-flop synchroniser on channel pins
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= CH_PIN_IN;
         sync2_reg <= sync1_reg;
      end
   end

   // tick speed divider from system tick by 2^tick_speed_select
   wire [7:0] tick_mask = 8'(8'hff >> (3'h7 - tick_sel_reg)) >> 1;
   wire tick_slow = TICK_EN && ((tick_div_reg & tick_mask[6:0]) == tick_mask[6:0]);
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tick_div_reg <= 7'h00;
      end else if (TICK_EN) begin
         tick_div_reg <= 7'(tick_div_reg + 7'h01);
      end
   end

   // axi write: address and data taken in either order, response after both
   wire wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   wire [7:0] wa = awaddr_reg;
   wire wa_t1 = (wa >= OFS_T1_BASE) && (wa < OFS_FLAG);
   wire [7:0] wa_loc = wa_t1 ? 8'(wa - OFS_T1_BASE) : wa;
   wire wa_tmr = (wa < OFS_FLAG) && (wa_loc <= OFS_T0_CC1) && (wa_loc[1:0] == 2'h0);
   wire wa_ok = wa_tmr || wa == OFS_FLAG || wa == OFS_TICK;
   wire wr_tmr = wr_fire && wa_tmr;
   wire wr_flag = wr_fire && wa == OFS_FLAG;
   wire wr_tick = wr_fire && wa == OFS_TICK;
   wire [1:0] wr_ctl = {wr_tmr && wa_t1 && wa_loc == OFS_T0_CTL, wr_tmr && !wa_t1 && wa_loc == OFS_T0_CTL};
   wire [1:0] clr_p = {wr_ctl[1] && wbyte_reg[CTL_CLR], wr_ctl[0] && wbyte_reg[CTL_CLR]};
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wbyte_reg <= 8'h00;
         bresp_reg <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_reg <= 1'b1;
            wbyte_reg <= S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : 8'h00;
         end
         if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= !wa_ok;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign S_AXI_AWREADY = !aw_got_reg && !bvalid_reg;
   assign S_AXI_WREADY = !w_got_reg && !bvalid_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg ? RESP_SLVERR : RESP_OKAY;

   // per-timer control registers; clear bit is write-only and reads zero
   for (genvar t = 0; t < 2; t++) begin : g_tmr
      wire sel = (t == 1) == wa_t1;
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
         if (!RST_N) begin
            ctl_reg[t] <= CTL_RESET;
            cctl_reg[t][0] <= CCTL_RESET;
            cctl_reg[t][1] <= CCTL_RESET;
         end else if (wr_tmr && sel) begin
            if (wa_loc == OFS_T0_CTL) ctl_reg[t] <= wbyte_reg & ~(8'h01 << CTL_CLR);
            if (wa_loc == OFS_T0_CCTL0) cctl_reg[t][0] <= wbyte_reg & 8'h7f;
            if (wa_loc == OFS_T0_CCTL1) cctl_reg[t][1] <= wbyte_reg & 8'h7f;
         end
      end
      // identical instance per timer
      dctmr_core u_core (
         .clk(CORE_CLK),
         .rst_n(RST_N),
         .tick_en(tick_slow),
         .ctl(ctl_reg[t]),
         .clr_pulse(clr_p[t]),
         .cctl(cctl_reg[t]),
         .cc_wr({wr_tmr && sel && wa_loc == OFS_T0_CC1, wr_tmr && sel && wa_loc == OFS_T0_CC0}),
         .cc_wdata(wbyte_reg),
         .pin_in(sync2_reg[2*t +: 2]),
         .count(count_w[t]),
         .cc_val(ccval_w[t]),
         .tc_event(tc_ev[t]),
         .ch_event(ch_ev[t]),
         .pin_out(pout[t]),
         .pin_oe(poe[t])
      );
      assign hw_set[FLG_PER_TMR*t +: FLG_PER_TMR] = {ch_ev[t], tc_ev[t]};
      assign irq_en[FLG_PER_TMR*t +: FLG_PER_TMR] = {cctl_reg[t][1][CCTL_IM], cctl_reg[t][0][CCTL_IM],
         ctl_reg[t][CTL_TCIM]};
      assign CH_PIN_OUT[2*t +: 2] = pout[t];
      assign CH_PIN_OE[2*t +: 2] = poe[t];
   end

   // shared flags: hardware set wins over software clear-by-writing-zero
   always_comb begin
      flag_next = flag_reg;
      if (wr_flag) flag_next = flag_reg & wbyte_reg[5:0];
      flag_next = flag_next | hw_set;
   end
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flag_reg <= 6'h00;
         irq_en_d_reg <= 6'h00;
         tick_sel_reg <= TICK_RESET;
      end else begin
         flag_reg <= flag_next;
         irq_en_d_reg <= irq_en;
         if (wr_tick) tick_sel_reg <= wbyte_reg[2:0];
      end
   end

   // request is a pulse: new event, or mask newly enabled over a pending flag
   assign rise_en = irq_en & ~irq_en_d_reg & flag_reg;
   wire [5:0] req = irq_en & (hw_set | rise_en);
   assign TMR_IRQ = {|req[5:3], |req[2:0]}; // one request per timer

   // axi read decode
   wire [7:0] ra = S_AXI_ARADDR;
   wire ra_t1 = (ra >= OFS_T1_BASE) && (ra < OFS_FLAG);
   wire [7:0] ra_loc = ra_t1 ? 8'(ra - OFS_T1_BASE) : ra;
   wire rt = ra_t1 ? 1'b1 : 1'b0;
   wire ra_tmr = (ra < OFS_FLAG) && (ra_loc <= OFS_T0_CC1) && (ra_loc[1:0] == 2'h0);
   wire [7:0] rbyte = (ra == OFS_FLAG) ? {2'h0, flag_reg} :
      (ra == OFS_TICK) ? {5'h00, tick_sel_reg} :
      (ra_loc == OFS_T0_CTL) ? ctl_reg[rt] :
      (ra_loc == OFS_T0_CNT) ? count_w[rt] :
      (ra_loc == OFS_T0_CCTL0) ? cctl_reg[rt][0] :
      (ra_loc == OFS_T0_CC0) ? ccval_w[rt][0] :
      (ra_loc == OFS_T0_CCTL1) ? cctl_reg[rt][1] : ccval_w[rt][1];
   wire ra_ok = ra_tmr || ra == OFS_FLAG || ra == OFS_TICK;
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= ra_ok ? {24'h00_0000, rbyte} : 32'h0000_0000;
         rresp_reg <= ra_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;

   // checks
   property p_tc_irq;
      @(posedge CORE_CLK) disable iff (!RST_N) (tc_ev[0] && ctl_reg[0][CTL_TCIM]) |-> TMR_IRQ[0];
   endproperty
   a_tc_irq: assert property (p_tc_irq) else $error("tc event without irq");
   property p_mask_off;
      @(posedge CORE_CLK) disable iff (!RST_N) (irq_en[2:0] == 3'h0) |-> !TMR_IRQ[0];
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq while masked");
   property p_flag_set;
      @(posedge CORE_CLK) disable iff (!RST_N) hw_set[0] |=> flag_reg[0];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_unmask;
      @(posedge CORE_CLK) disable iff (!RST_N) $rose(ctl_reg[0][CTL_TCIM]) && flag_reg[0] |-> TMR_IRQ[0];
   endproperty
   a_unmask: assert property (p_unmask) else $error("no irq on unmask");
   property p_clear;
      @(posedge CORE_CLK) disable iff (!RST_N) clr_p[0] |=> count_w[0] == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear missed");
   property p_halt;
      @(posedge CORE_CLK) disable iff (!RST_N) (!ctl_reg[0][CTL_START] && !clr_p[0]) |=> $stable(count_w[0]);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved while halted");
   sequence s_wr_done;
      wr_fire ##1 S_AXI_BVALID;
   endsequence
   property p_bresp;
      @(posedge CORE_CLK) disable iff (!RST_N) wr_fire |-> s_wr_done;
   endproperty
   a_bresp: assert property (p_bresp) else $error("no write response");
   property p_oe;
      @(posedge CORE_CLK) disable iff (!RST_N) CH_PIN_OE[0] == cctl_reg[0][0][CCTL_CMPMODE];
   endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
endmodule : dctmr_top

// ---- hdl/dctmr_pkg.sv ----
// package: register map, field positions, reset values and codes for the dual 8-bit timer
package dctmr_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] OFS_T0_CTL = 8'h00;
   localparam logic [7:0] OFS_T0_CNT = 8'h04;
   localparam logic [7:0] OFS_T0_CCTL0 = 8'h08;
   localparam logic [7:0] OFS_T0_CC0 = 8'h0c;
   localparam logic [7:0] OFS_T0_CCTL1 = 8'h10;
   localparam logic [7:0] OFS_T0_CC1 = 8'h14;
   localparam logic [7:0] OFS_T1_BASE = 8'h20;
   localparam logic [7:0] OFS_FLAG = 8'h40;
   localparam logic [7:0] OFS_TICK = 8'h44;
   // timer control fields
   localparam int CTL_DIV_LSB = 5;
   localparam int CTL_START = 4;
   localparam int CTL_TCIM = 3;
   localparam int CTL_CLR = 2;
   localparam int CTL_MODE_LSB = 0;
   localparam logic [7:0] CTL_RESET = 8'h08;
   // channel control fields
   localparam int CCTL_IM = 6;
   localparam int CCTL_ACT_LSB = 3;
   localparam int CCTL_CMPMODE = 2;
   localparam int CCTL_EDGE_LSB = 0;
   localparam logic [7:0] CCTL_RESET = 8'h40;
   localparam logic [7:0] CC_RESET = 8'h00;
   localparam logic [2:0] TICK_RESET = 3'h0;
   // flag bit positions: per timer, terminal count then channels
   localparam int FLG_PER_TMR = 3;
   // counter modes
   localparam logic [1:0] MODE_FREE = 2'h0;
   localparam logic [1:0] MODE_DOWN = 2'h1;
   localparam logic [1:0] MODE_MOD = 2'h2;
   localparam logic [1:0] MODE_UPDN = 2'h3;
   // compare output actions
   localparam logic [2:0] ACT_SET = 3'h0;
   localparam logic [2:0] ACT_CLR = 3'h1;
   localparam logic [2:0] ACT_TGL = 3'h2;
   localparam logic [2:0] ACT_SETUP = 3'h3;
   localparam logic [2:0] ACT_CLRUP = 3'h4;
   localparam logic [2:0] ACT_SETFF = 3'h5;
   localparam logic [2:0] ACT_CLR00 = 3'h6;
   // capture edge selection
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int ADDR_W = 8;
endpackage : dctmr_pkg

// ---- hdl/dctmr_core.sv ----
// one 8-bit timer: prescaler, counter and two capture/compare channels
`timescale 1ns/1ps
module dctmr_core
   import dctmr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration from registers
   input wire logic tick_en,
   input wire logic [7:0] ctl,
   input wire logic clr_pulse,
   input wire logic [7:0] cctl [2],
   input wire logic [1:0] cc_wr,
   input wire logic [7:0] cc_wdata,
   // synchronised channel inputs
   input wire logic [1:0] pin_in,
   // state and events
   output logic [7:0] count,
   output logic [7:0] cc_val [2],
   output logic tc_event,
   output logic [1:0] ch_event,
   output logic [1:0] pin_out,
   output logic [1:0] pin_oe
);
   logic [6:0] pre_reg;
   logic [7:0] cnt_reg, cnt_next;
   logic down_reg, down_next;
   logic loaded_reg;
   logic [7:0] cc0_shadow_reg;
   logic [7:0] cc0_live_reg;
   logic [7:0] cc_reg [2];
   logic [1:0] pin_d_reg;
   logic [1:0] out_reg;
   logic tc_reg;
   logic [1:0] ev_reg;
   wire start = ctl[CTL_START];
   wire [1:0] mode = ctl[CTL_MODE_LSB +: 2];
   wire [2:0] div = ctl[CTL_DIV_LSB +: 3];
   wire [7:0] div_mask = 8'(8'hff >> (3'h7 - div)) >> 1;
   // active edge: tick with prescale count all ones on the selected bits
   wire active = tick_en && start && ((pre_reg & div_mask[6:0]) == div_mask[6:0]);
   wire [7:0] top = cc0_live_reg;
   wire hit_tc;

   // next count per mode
   always_comb begin
      cnt_next = cnt_reg;
      down_next = down_reg;
      case (mode)
         MODE_FREE: cnt_next = 8'(cnt_reg + 8'h01); // wraps 0xff to 0x00
         MODE_DOWN: cnt_next = (cnt_reg == 8'h00) ? 8'h00 : 8'(cnt_reg - 8'h01);
         MODE_MOD: cnt_next = (cnt_reg >= top) ? 8'h00 : 8'(cnt_reg + 8'h01);
         default: begin
            if (!down_reg && cnt_reg >= top) begin
               down_next = (top != 8'h00);
               cnt_next = (top == 8'h00) ? 8'h00 : 8'(cnt_reg - 8'h01);
            end else if (down_reg && cnt_reg == 8'h01) begin
               down_next = 1'b0; // turn at zero for centre-aligned periods
               cnt_next = 8'h00;
            end else begin
               cnt_next = down_reg ? 8'(cnt_reg - 8'h01) : 8'(cnt_reg + 8'h01);
            end
         end
      endcase
   end

   // terminal count per mode
   assign hit_tc = active && loaded_reg && ((mode == MODE_FREE && cnt_reg == 8'hff) ||
      (mode == MODE_DOWN && cnt_reg == 8'h01) || (mode == MODE_MOD && cnt_reg >= top) ||
      (mode == MODE_UPDN && down_reg && cnt_reg == 8'h01));

   // prescaler only runs while started; halt keeps the count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= 7'h00;
      end else if (clr_pulse || !start) begin
         pre_reg <= 7'h00;
      end else if (tick_en) begin
         pre_reg <= 7'(pre_reg + 7'h01);
      end
   end

   // counter, direction and down-mode load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         down_reg <= 1'b0;
         loaded_reg <= 1'b0;
         tc_reg <= 1'b0;
      end else begin
         tc_reg <= hit_tc;
         if (clr_pulse) begin
            cnt_reg <= 8'h00; // clear also resets direction
            down_reg <= 1'b0;
            loaded_reg <= 1'b0;
         end else if (!start) begin
            loaded_reg <= 1'b0;
         end else if (!loaded_reg) begin
            loaded_reg <= 1'b1;
            if (mode == MODE_DOWN) begin
               cnt_reg <= cc_reg[0]; // load on start in down mode
            end
         end else if (active) begin
            cnt_reg <= cnt_next;
            down_reg <= down_next;
         end
      end
   end

   // channel 0 compare value shadowed until count is zero; channel 1 live
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cc0_shadow_reg <= CC_RESET;
         cc0_live_reg <= CC_RESET;
      end else begin
         if (cc_wr[0]) begin
            cc0_shadow_reg <= cc_wdata;
         end
         if (cnt_reg == 8'h00) begin
            cc0_live_reg <= cc_wr[0] ? cc_wdata : cc0_shadow_reg;
         end
      end
   end

   // per-channel capture and compare
   for (genvar n = 0; n < 2; n++) begin : g_ch
      wire is_cmp = cctl[n][CCTL_CMPMODE];
      wire [1:0] edge_sel = cctl[n][CCTL_EDGE_LSB +: 2];
      wire [2:0] act = cctl[n][CCTL_ACT_LSB +: 3];
      wire rise = pin_in[n] && !pin_d_reg[n];
      wire fall = !pin_in[n] && pin_d_reg[n];
      // capture on selected edge once started
      wire cap = !is_cmp && start && loaded_reg &&
         ((edge_sel == EDGE_RISE && rise) || (edge_sel == EDGE_FALL && fall) ||
         (edge_sel == EDGE_ANY && (rise || fall)));
      wire [7:0] cmp_val = (n == 0) ? cc0_live_reg : cc_reg[n];
      // match judged once per active edge so output moves once per count
      wire match = is_cmp && active && loaded_reg && cnt_reg == cmp_val;
      wire at_zero = is_cmp && active && loaded_reg && cnt_reg == 8'h00;
      wire at_ff = is_cmp && active && loaded_reg && cnt_reg == 8'hff;
      logic out_next;
      // compare output action
      always_comb begin
         out_next = out_reg[n];
         case (act)
            ACT_SET: out_next = match ? 1'b1 : out_reg[n];
            ACT_CLR: out_next = match ? 1'b0 : out_reg[n];
            ACT_TGL: out_next = match ? !out_reg[n] : out_reg[n];
            ACT_SETUP: begin
               if (match) out_next = !(mode == MODE_UPDN && down_reg);
               else if (at_zero) out_next = 1'b0;
            end
            ACT_CLRUP: begin
               if (match) out_next = (mode == MODE_UPDN && down_reg);
               else if (at_zero) out_next = 1'b1;
            end
            ACT_SETFF: begin
               if (match) out_next = 1'b1;
               else if (at_ff) out_next = 1'b0;
            end
            ACT_CLR00: begin
               if (match) out_next = 1'b0;
               else if (at_zero) out_next = 1'b1;
            end
            default: out_next = out_reg[n];
         endcase
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pin_d_reg[n] <= 1'b0;
            out_reg[n] <= 1'b0;
            ev_reg[n] <= 1'b0;
            cc_reg[n] <= CC_RESET;
         end else begin
            pin_d_reg[n] <= pin_in[n];
            out_reg[n] <= out_next; // registered so the pin is glitch free
            ev_reg[n] <= cap || match;
            if (cap) begin
               cc_reg[n] <= cnt_reg;
            end else if (cc_wr[n]) begin
               cc_reg[n] <= cc_wdata;
            end
         end
      end
      assign pin_oe[n] = is_cmp; // pin direction follows channel mode
   end

   assign count = cnt_reg;
   // channel 0 shows the pending compare value, or the captured count in capture mode
   assign cc_val[0] = cctl[0][CCTL_CMPMODE] ? cc0_shadow_reg : cc_reg[0];
   assign cc_val[1] = cc_reg[1];
   assign tc_event = tc_reg;
   assign ch_event = ev_reg;
   assign pin_out = out_reg;
endmodule : dctmr_core

// ---- bench/dctmr_pin_model.sv ----
// far side of the channel pins: event source and pin load
`timescale 1ns/1ps
module dctmr_pin_model (
   // clock
   input wire logic clk,
   // commanded levels and pin direction
   input wire logic [3:0] pulse,
   input wire logic [3:0] pin_oe,
   // level seen by the timer
   output logic [3:0] pin_in = 4'h0
);
   // a pin driven by the timer is not ours: feed a changing pattern, not a stale level
   always @(posedge clk) begin
      pin_in <= (pin_oe & ~pin_in) | (~pin_oe & pulse);
   end
endmodule : dctmr_pin_model

// ---- bench/tb.sv ----
// testbench: dual 8-bit timer over axi4-lite against a pin model
`timescale 1ns/1ps
module tb;
   import dctmr_pkg::*;
   logic clk = 0, rst_n = 0, tick = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
   logic awr, wr_r, bv, arr, rv;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdt, rd;
   logic [1:0] brs, rrs, rs, bs, irq, seen = 2'h0;
   logic [3:0] pin_in, pin_out, pin_oe, pulse = 4'h0;
   int mismatches = 0, samples_checked = 0, cyc = 0, e, v, m, j, w, h;
   always #5 clk = ~clk;
   // irq pulses are one cycle: latch them, and cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      seen <= seen | irq;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   dctmr_top i_dctmr_top (.CORE_CLK(clk), .RST_N(rst_n), .TICK_EN(tick), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdt), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy),
      .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out), .CH_PIN_OE(pin_oe), .TMR_IRQ(irq));
   dctmr_pin_model i_dctmr_pin_model (.clk(clk), .pulse(pulse), .pin_oe(pin_oe), .pin_in(pin_in));
   task summarize;
      $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   // each channel released at its own handshake edge; ready looked at mid-cycle, where it is settled
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic ah, wh, ta, tw, tk;
      ah = 0;
      wh = 0;
      tk = 0;
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      brdy <= 1;
      while (!(ah && wh)) begin
         @(negedge clk);
         ta = !ah && awr;
         tw = !wh && wr_r;
         @(posedge clk);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         ah = ah || ta;
         wh = wh || tw;
      end
      while (!tk) begin
         @(negedge clk);
         tk = bv;
         bs = brs;
         @(posedge clk);
      end
      brdy <= 0;
      @(posedge clk);
   endtask : wr
   task rdr(input logic [7:0] a);
      logic tk;
      tk = 0;
      ara <= a;
      arv <= 1;
      rrdy <= 1;
      while (!tk) begin
         @(negedge clk);
         tk = arr;
         @(posedge clk);
      end
      arv <= 0;
      tk = 0;
      while (!tk) begin
         @(negedge clk);
         tk = rv;
         rd = rdt;
         rs = rrs;
         @(posedge clk);
      end
      rrdy <= 0;
      @(posedge clk);
   endtask : rdr
   initial begin
      void'($urandom(56008));
      repeat (10) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rdr(OFS_T0_CTL); chk(rd, {24'h0, CTL_RESET});
      wr(OFS_T0_CTL, 8'h18);
      chk(bs, RESP_OKAY);
      repeat (300) @(posedge clk);
      rdr(OFS_FLAG); chk(rd[0], 1);
      chk(seen[0], 1);
      wr(OFS_T0_CTL, 8'h0c);
      repeat (20) @(posedge clk);
      rdr(OFS_T0_CNT); chk(rd, 0);
      wr(OFS_FLAG, 8'h00);
      rdr(OFS_FLAG); chk(rd, 0);
      // mask off: flag but no request, then enabling the mask requests
      wr(OFS_T0_CTL, 8'h10);
      // cleared mid-cycle so the latch process cannot race it
      @(negedge clk);
      seen = 2'h0;
      @(posedge clk);
      repeat (300) @(posedge clk);
      chk(seen[0], 0);
      wr(OFS_T0_CTL, 8'h08);
      chk(seen[0], 1);
      wr(OFS_T0_CTL, 8'h18);
      // every edge code, rising then falling
      for (e = 0; e < 4; e++) begin
         wr(OFS_T0_CCTL0, 8'h40 | e[7:0]);
         wr(OFS_FLAG, 8'h00);
         pulse[0] <= 1;
         repeat (6) @(posedge clk);
         rdr(OFS_FLAG); chk(rd[1], e[0]);
         wr(OFS_FLAG, 8'h00);
         pulse[0] <= 0;
         repeat (6) @(posedge clk);
         rdr(OFS_FLAG); chk(rd[1], e[1]);
      end
      // down, modulo and up/down against a top of 5, halted mid-run: count read at the halt not above top, zero in down mode
      wr(OFS_T0_CC0, 8'h05);
      for (m = 1; m < 4; m++) begin
         wr(OFS_T0_CTL, 8'h0c);
         wr(OFS_FLAG, 8'h00);
         wr(OFS_T0_CTL, 8'h18 | m[7:0]);
         repeat (40) @(posedge clk);
         wr(OFS_T0_CTL, 8'h08 | m[7:0]);
         rdr(OFS_T0_CNT);
         chk(rd <= ((m == 1) ? 0 : 5), 1);
         rdr(OFS_FLAG);
         chk(rd[0], 1);
      end
      v = $urandom_range(254, 1);
      wr(OFS_T1_BASE + 8'h0c, v[7:0]);
      wr(OFS_T1_BASE + 8'h08, 8'h44);
      wr(OFS_T1_BASE, 8'h18);
      repeat (600) @(posedge clk);
      chk({pin_oe[2], pin_out[2]}, 2'h3);
      rdr(OFS_FLAG); chk(rd[4], 1);
      chk(seen[1], 1);
      // pwm on timer 1 channel 1 with the preferred actions: high time per 256-count period
      w = $urandom_range(250, 2);
      wr(OFS_T1_BASE + 8'h14, w[7:0]);
      for (j = 4; j < 6; j++) begin
         wr(OFS_T1_BASE + 8'h10, 8'h44 | (j[7:0] << 3));
         repeat (260) @(posedge clk);
         h = 0;
         repeat (256) begin
            @(negedge clk);
            h += pin_out[3];
         end
         @(posedge clk);
         chk(h, (j == 4) ? w : 255 - w);
      end
      rdr(8'h48); chk({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
      wr(8'h48, 8'h00);
      chk(bs, RESP_SLVERR);
      summarize();
   end
endmodule : tb
